// >>> i2cr_pkg.sv
`default_nettype none
package i2cr_pkg;
  // Two serial units share this register block.
  localparam int NUM_UNITS = 2;
  localparam int PRE_W     = 16;
  localparam int BYTE_W    = 8;
  localparam int ADDR_W    = 8;
  localparam int TADDR_W   = 10;
  localparam int TGT_W     = 16;
  // High prescale byte weight is 256, a shift by eight.
  localparam int PRE_HI_SHIFT = 8;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // Per-unit window: unit select bit and offsets within the window.
  localparam int UNIT_SEL_BIT = 5;
  localparam logic [1:0] UNIT_REGION = 2'h0;
  localparam logic [4:0] OFF_PRE_LO = 5'h00;
  localparam logic [4:0] OFF_PRE_HI = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_RXBUF  = 5'h0C;
  localparam logic [4:0] OFF_TXBUF  = 5'h10;
  localparam logic [4:0] OFF_TARGET = 5'h14;
  localparam logic [4:0] OFF_EVT_IE = 5'h18;
  // Shared enable and flag registers of the two units.
  localparam logic [7:0] OFF_IE_U0  = 8'h40;
  localparam logic [7:0] OFF_IFG_U0 = 8'h44;
  localparam logic [7:0] OFF_IE_U1  = 8'h48;
  localparam logic [7:0] OFF_IFG_U1 = 8'h4C;

  // Shared flag and enable bit positions.
  localparam int BIT_TX = 3;
  localparam int BIT_RX = 2;
  // Status bit positions; the event enables use bits 3 to 0 alike.
  localparam int ST_SCL_LOW = 6;
  localparam int ST_GC      = 5;
  localparam int ST_BUSY    = 4;
  localparam int ST_NACK    = 3;
  localparam int ST_STOP    = 2;
  localparam int ST_START   = 1;
  localparam int ST_AL      = 0;
  localparam int EVT_N      = 5;
  localparam int IE_N       = 4;
  // Index of each event inside the event vector.
  localparam int EV_AL    = 0;
  localparam int EV_START = 1;
  localparam int EV_STOP  = 2;
  localparam int EV_NACK  = 3;
  localparam int EV_GC    = 4;
  localparam logic TX_FLAG_RST = 1'b1;
  localparam logic RX_FLAG_RST = 1'b0;

  typedef struct packed {
    logic       gc;
    logic       nack;
    logic       stop;
    logic       start;
    logic       al;
  } i2cr_evt_t;

  typedef struct packed {
    i2cr_evt_t  evt;
    logic       busy;
    logic       scl_low;
    logic       master;
    logic       addr10;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_take;
    logic       src_tick;
  } i2cr_eng_in_t;

  typedef struct packed {
    logic [7:0] tx_data;
    logic       tx_full;
    logic [9:0] target;
    logic       bit_tick;
  } i2cr_eng_out_t;
endpackage : i2cr_pkg
`default_nettype wire

// >>> i2cr_flag.sv
`timescale 1ns/1ps
`default_nettype none
module i2cr_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Set and clear
  input  wire logic set_i,
  input  wire logic clr_i,
  // Flag
  output logic      q_o
);
  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      q_o <= RST_VAL;
    else if (set_i)
      q_o <= 1'b1;
    else if (clr_i)
      q_o <= 1'b0;
  end
endmodule : i2cr_flag
`default_nettype wire

// >>> i2cr_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module i2cr_prescale #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // Source clock enable and divider
  input  wire logic         src_tick_i,
  input  wire logic [W-1:0] div_i,
  // Bit clock enable
  output logic              tick_o
);
  logic [W-1:0] cnt_r;
  logic         last;

  // Divider values of zero and one both pass every source tick.
  assign last = (div_i <= W'(1)) || (cnt_r >= div_i - W'(1));

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= src_tick_i & last;
      if (src_tick_i)
        cnt_r <= last ? '0 : cnt_r + W'(1);
    end
  end
endmodule : i2cr_prescale
`default_nettype wire

// >>> i2cr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Prescale equals low byte plus high times 256.
// - Receive buffer keeps last received character, readable.
// - Reading receive buffer clears its receive flag.
// - Transmit buffer holds written byte until sent.
// - Writing transmit buffer clears its transmit flag.
// - Unit 0 transmit flag bit 3, reset one.
// - Unit 0 receive flag bit 2 on character.
// - Unit 1 flags: transmit bit 3, receive 2.
// - Target address used only in master mode.
// - Seven-bit target: bit 6 MSB, 9-7 ignored.
// - Ten-bit target: bit 9 is MSB.
// - Unit 0 transmit enable bit 3 gates request.
// - Unit 0 receive enable bit 2 gates request.
// - Unit 1 enables bits 3, 2, reset zero.
module i2cr_regs (
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  // AHB-Lite slave
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic [31:0]                hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  // Protocol engine side, one entry per unit
  input  wire i2cr_pkg::i2cr_eng_in_t  [i2cr_pkg::NUM_UNITS-1:0] eng_i,
  output i2cr_pkg::i2cr_eng_out_t      [i2cr_pkg::NUM_UNITS-1:0] eng_o,
  // Interrupt
  output logic                       irq_o
);
  localparam int NU = i2cr_pkg::NUM_UNITS;

  logic                               acc;
  logic                               dp_wr_r;
  logic                               rd_wait_r;
  logic [i2cr_pkg::ADDR_W-1:0]        dp_addr_r;
  logic                               in_unit;
  logic [4:0]                         off;
  logic [31:0]                        rdata_nxt;
  logic [31:0]                        hrdata_r;
  logic                               irq_nxt;
  logic                               irq_r;

  logic [NU-1:0][i2cr_pkg::PRE_W-1:0]   pre_r;
  logic [NU-1:0][7:0]                   rx_r;
  logic [NU-1:0][7:0]                   tx_r;
  logic [NU-1:0][i2cr_pkg::TGT_W-1:0]   sa_r;
  logic [NU-1:0][i2cr_pkg::IE_N-1:0]    eie_r;
  logic [NU-1:0][1:0]                   uie_r;
  logic [NU-1:0]                        busy_r;
  logic [NU-1:0]                        scl_low_r;
  logic [NU-1:0][i2cr_pkg::TADDR_W-1:0] target_r;
  logic [NU-1:0][i2cr_pkg::EVT_N-1:0]   evf;
  logic [NU-1:0]                        rxf;
  logic [NU-1:0]                        txf;
  logic [NU-1:0]                        tick;
  logic [NU-1:0]                        rd_rx;
  logic [NU-1:0]                        wr_tx;
  logic [NU-1:0]                        wr_stat;
  logic [NU-1:0]                        wr_ifg;

  // Address phase is taken whenever the bus is ready; reads add one wait.
  assign acc = hsel_i & htrans_i[i2cr_pkg::HTRANS_ACTIVE_BIT] & hready_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      dp_wr_r   <= 1'b0;
      rd_wait_r <= 1'b0;
      dp_addr_r <= '0;
    end
    else
    begin
      dp_wr_r   <= acc & hwrite_i;
      rd_wait_r <= acc & ~hwrite_i;
      if (acc)
        dp_addr_r <= haddr_i[i2cr_pkg::ADDR_W-1:0];
    end
  end

  // The wait state lets a read see a write that ended one cycle before.
  assign hreadyout_o = ~rd_wait_r;
  assign hresp_o     = i2cr_pkg::HRESP_OKAY;
  assign in_unit     = dp_addr_r[7:6] == i2cr_pkg::UNIT_REGION;
  assign off         = dp_addr_r[4:0];

  for (genvar u = 0; u < NU; u++)
  begin : g_unit
    localparam logic [7:0] IE_ADDR  = (u == 0) ? i2cr_pkg::OFF_IE_U0 : i2cr_pkg::OFF_IE_U1;
    localparam logic [7:0] IFG_ADDR = (u == 0) ? i2cr_pkg::OFF_IFG_U0 : i2cr_pkg::OFF_IFG_U1;
    logic                          sel;
    logic                          wr_ie;
    logic [i2cr_pkg::EVT_N-1:0]    ev_set;
    logic [i2cr_pkg::EVT_N-1:0]    ev_clr;
    logic [i2cr_pkg::BYTE_W-1:0]   wb;

    assign sel        = in_unit && (dp_addr_r[i2cr_pkg::UNIT_SEL_BIT] == 1'(u));
    assign wb         = hwdata_i[i2cr_pkg::BYTE_W-1:0];
    assign rd_rx[u]   = rd_wait_r & sel & (off == i2cr_pkg::OFF_RXBUF);
    assign wr_tx[u]   = dp_wr_r & sel & (off == i2cr_pkg::OFF_TXBUF);
    assign wr_stat[u] = dp_wr_r & sel & (off == i2cr_pkg::OFF_STATUS);
    assign wr_ifg[u]  = dp_wr_r & (dp_addr_r == IFG_ADDR);
    assign wr_ie      = dp_wr_r & (dp_addr_r == IE_ADDR);

    always_ff @(posedge sys_clk_i)
    begin
      if (!rst_n_i)
      begin
        pre_r[u] <= '0;
        sa_r[u]  <= '0;
        eie_r[u] <= '0;
        uie_r[u] <= '0;
      end
      else if (dp_wr_r)
      begin
        if (sel && off == i2cr_pkg::OFF_PRE_LO)
          pre_r[u][i2cr_pkg::PRE_HI_SHIFT-1:0] <= wb;
        if (sel && off == i2cr_pkg::OFF_PRE_HI)
          pre_r[u][i2cr_pkg::PRE_W-1:i2cr_pkg::PRE_HI_SHIFT] <= wb;
        if (sel && off == i2cr_pkg::OFF_TARGET)
          sa_r[u] <= hwdata_i[i2cr_pkg::TGT_W-1:0];
        if (sel && off == i2cr_pkg::OFF_EVT_IE)
          eie_r[u] <= wb[i2cr_pkg::IE_N-1:0];
        if (wr_ie)
          uie_r[u] <= {wb[i2cr_pkg::BIT_TX], wb[i2cr_pkg::BIT_RX]};
      end
    end

    // Receive byte capture, transmit byte hold and level sampling.
    always_ff @(posedge sys_clk_i)
    begin
      if (!rst_n_i)
      begin
        rx_r[u]      <= '0;
        tx_r[u]      <= '0;
        busy_r[u]    <= 1'b0;
        scl_low_r[u] <= 1'b0;
      end
      else
      begin
        if (eng_i[u].rx_valid)
          rx_r[u] <= eng_i[u].rx_data;
        if (wr_tx[u])
          tx_r[u] <= wb;
        busy_r[u]    <= eng_i[u].busy;
        scl_low_r[u] <= eng_i[u].scl_low;
      end
    end

    // The target address is zero while in slave mode.
    always_ff @(posedge sys_clk_i)
    begin
      if (!rst_n_i)
        target_r[u] <= '0;
      else if (!eng_i[u].master)
        target_r[u] <= '0;
      else if (eng_i[u].addr10)
        target_r[u] <= sa_r[u][i2cr_pkg::TADDR_W-1:0];
      else
        target_r[u] <= {3'h0, sa_r[u][6:0]};
    end

    // Event flags are cleared by writing one; a stop also ends the start flag.
    assign ev_set = eng_i[u].evt;
    always_comb
    begin
      ev_clr = wr_stat[u] ? {wb[i2cr_pkg::ST_GC], wb[i2cr_pkg::ST_NACK:i2cr_pkg::ST_AL]} : '0;
      ev_clr[i2cr_pkg::EV_START] = ev_clr[i2cr_pkg::EV_START] | eng_i[u].evt.stop;
    end

    for (genvar b = 0; b < i2cr_pkg::EVT_N; b++)
    begin : g_evt
      i2cr_flag #(
        .RST_VAL (1'b0)
      ) u_evt (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .set_i     (ev_set[b]),
        .clr_i     (ev_clr[b]),
        .q_o       (evf[u][b])
      );
    end

    i2cr_flag #(
      .RST_VAL (i2cr_pkg::RX_FLAG_RST)
    ) u_rxf (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .set_i     (eng_i[u].rx_valid),
      .clr_i     (rd_rx[u] | (wr_ifg[u] & wb[i2cr_pkg::BIT_RX])),
      .q_o       (rxf[u])
    );

    i2cr_flag #(
      .RST_VAL (i2cr_pkg::TX_FLAG_RST)
    ) u_txf (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .set_i     (eng_i[u].tx_take),
      .clr_i     (wr_tx[u] | (wr_ifg[u] & wb[i2cr_pkg::BIT_TX])),
      .q_o       (txf[u])
    );

    i2cr_prescale #(
      .W (i2cr_pkg::PRE_W)
    ) u_pre (
      .sys_clk_i  (sys_clk_i),
      .rst_n_i    (rst_n_i),
      .src_tick_i (eng_i[u].src_tick),
      .div_i      (pre_r[u]),
      .tick_o     (tick[u])
    );

    assign eng_o[u].tx_data  = tx_r[u];
    assign eng_o[u].tx_full  = ~txf[u];
    assign eng_o[u].target   = target_r[u];
    assign eng_o[u].bit_tick = tick[u];
  end

  // Read data are formed from the captured address during the wait state.
  always_comb
  begin
    rdata_nxt = '0;
    for (int k = 0; k < NU; k++)
    begin
      if (in_unit && dp_addr_r[i2cr_pkg::UNIT_SEL_BIT] == k[0])
      begin
        unique case (off)
          i2cr_pkg::OFF_PRE_LO: rdata_nxt[7:0] = pre_r[k][7:0];
          i2cr_pkg::OFF_PRE_HI: rdata_nxt[7:0] = pre_r[k][15:8];
          i2cr_pkg::OFF_STATUS:
          begin
            rdata_nxt[i2cr_pkg::ST_SCL_LOW] = scl_low_r[k];
            rdata_nxt[i2cr_pkg::ST_GC]      = evf[k][i2cr_pkg::EV_GC];
            rdata_nxt[i2cr_pkg::ST_BUSY]    = busy_r[k];
            rdata_nxt[i2cr_pkg::ST_NACK]    = evf[k][i2cr_pkg::EV_NACK];
            rdata_nxt[i2cr_pkg::ST_STOP]    = evf[k][i2cr_pkg::EV_STOP];
            rdata_nxt[i2cr_pkg::ST_START]   = evf[k][i2cr_pkg::EV_START];
            rdata_nxt[i2cr_pkg::ST_AL]      = evf[k][i2cr_pkg::EV_AL];
          end
          i2cr_pkg::OFF_RXBUF:  rdata_nxt[7:0] = rx_r[k];
          i2cr_pkg::OFF_TXBUF:  rdata_nxt[7:0] = tx_r[k];
          i2cr_pkg::OFF_TARGET: rdata_nxt[15:0] = sa_r[k];
          i2cr_pkg::OFF_EVT_IE: rdata_nxt[3:0] = eie_r[k];
          default:              rdata_nxt = '0;
        endcase
      end
    end
    unique case (dp_addr_r)
      i2cr_pkg::OFF_IE_U0:
      begin
        rdata_nxt[i2cr_pkg::BIT_TX] = uie_r[0][1];
        rdata_nxt[i2cr_pkg::BIT_RX] = uie_r[0][0];
      end
      i2cr_pkg::OFF_IFG_U0:
      begin
        rdata_nxt[i2cr_pkg::BIT_TX] = txf[0];
        rdata_nxt[i2cr_pkg::BIT_RX] = rxf[0];
      end
      i2cr_pkg::OFF_IE_U1:
      begin
        rdata_nxt[i2cr_pkg::BIT_TX] = uie_r[1][1];
        rdata_nxt[i2cr_pkg::BIT_RX] = uie_r[1][0];
      end
      i2cr_pkg::OFF_IFG_U1:
      begin
        rdata_nxt[i2cr_pkg::BIT_TX] = txf[1];
        rdata_nxt[i2cr_pkg::BIT_RX] = rxf[1];
      end
      default:
      begin
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      hrdata_r <= '0;
    else if (rd_wait_r)
      hrdata_r <= rdata_nxt;
  end

  assign hrdata_o = hrdata_r;

  // One level interrupt collects every enabled request of both units.
  always_comb
  begin
    irq_nxt = 1'b0;
    for (int k = 0; k < NU; k++)
    begin
      irq_nxt = irq_nxt | (|(evf[k][i2cr_pkg::IE_N-1:0] & eie_r[k]));
      irq_nxt = irq_nxt | (txf[k] & uie_r[k][1]);
      irq_nxt = irq_nxt | (rxf[k] & uie_r[k][0]);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      irq_r <= 1'b0;
    else
      irq_r <= irq_nxt;
  end

  assign irq_o = irq_r;

  a_rx_read_clr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_rx[0] && !eng_i[0].rx_valid |=> !rxf[0])
    else $error("receive flag not cleared by buffer read");

  a_tx_write_clr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_tx[0] && !eng_i[0].tx_take |=> !txf[0] && eng_o[0].tx_full)
    else $error("transmit flag not cleared by buffer write");

  a_tx_reset_one: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> txf[0] && txf[1] && !rxf[0] && uie_r[1] == 2'h0)
    else $error("flag or enable reset value wrong");

  a_rx_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eng_i[1].rx_valid |=> rxf[1] && rx_r[1] == $past(eng_i[1].rx_data))
    else $error("received character not captured");

  a_tx_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_tx[0] ##1 (!wr_tx[0])[*2] |-> eng_o[0].tx_data == $past(hwdata_i[7:0], 2))
    else $error("transmit byte not held");

  a_start_on_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eng_i[0].evt.stop && !eng_i[0].evt.start |=> !evf[0][i2cr_pkg::EV_START])
    else $error("start flag survived a stop");

  a_target_seven: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eng_i[0].master && !eng_i[0].addr10 |=> eng_o[0].target == {3'h0, $past(sa_r[0][6:0])})
    else $error("seven-bit target address wrong");

  a_target_slave: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !eng_i[0].master |=> eng_o[0].target == 10'h000)
    else $error("target address driven in slave mode");

  a_irq_tx_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    txf[0] && uie_r[0][1] |=> irq_o)
    else $error("enabled transmit request gave no interrupt");

  a_event_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eng_i[1].evt.nack ##1 eie_r[1][i2cr_pkg::ST_NACK] |=> irq_o)
    else $error("enabled nack event gave no interrupt");

  a_read_wait: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    acc && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
endmodule : i2cr_regs
`default_nettype wire

// >>> i2cr_eng_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2cr_eng_model (
  // Clock
  input  wire logic                                          sys_clk_i,
  // Engine side of the register block
  output var i2cr_pkg::i2cr_eng_in_t [i2cr_pkg::NUM_UNITS-1:0] eng_o
);
  initial eng_o = '0;

  // The source clock enable runs at half the system rate, so a bit clock gap is twice the divider.
  always @(posedge sys_clk_i)
  begin
    for (int u = 0; u < i2cr_pkg::NUM_UNITS; u++)
    begin
      eng_o[u].src_tick <= ~eng_o[u].src_tick;
    end
  end

  task evt(input int u, input i2cr_pkg::i2cr_evt_t e);
    eng_o[u].evt <= e;
    @(posedge sys_clk_i);
    eng_o[u].evt <= '0;
  endtask : evt

  // The data lines show the inverse once the pulse is gone, so a stale value cannot pass for a capture.
  task rx(input int u, input logic [7:0] d);
    eng_o[u].rx_valid <= 1'b1;
    eng_o[u].rx_data  <= d;
    @(posedge sys_clk_i);
    eng_o[u].rx_valid <= 1'b0;
    eng_o[u].rx_data  <= ~d;
  endtask : rx

  task take(input int u);
    eng_o[u].tx_take <= 1'b1;
    @(posedge sys_clk_i);
    eng_o[u].tx_take <= 1'b0;
  endtask : take

  task lvl(input int u, input logic busy, input logic scl_low, input logic master, input logic addr10);
    eng_o[u].busy    <= busy;
    eng_o[u].scl_low <= scl_low;
    eng_o[u].master  <= master;
    eng_o[u].addr10  <= addr10;
  endtask : lvl
endmodule : i2cr_eng_model
`default_nettype wire

// >>> i2c_serial_unit_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_serial_unit_registers_tb_top;
  logic                                               sys_clk_i;
  logic                                               rst_n_i;
  logic                                               hsel;
  logic [31:0]                                        haddr;
  logic [1:0]                                         htrans;
  logic                                               hwrite;
  logic [2:0]                                         hsize;
  logic [31:0]                                        hwdata;
  logic [31:0]                                        hrdata;
  logic                                               hready;
  logic                                               hresp;
  logic                                               irq;
  i2cr_pkg::i2cr_eng_in_t  [i2cr_pkg::NUM_UNITS-1:0]  eng_in;
  i2cr_pkg::i2cr_eng_out_t [i2cr_pkg::NUM_UNITS-1:0]  eng_out;
  int                                                 err_count;
  int                                                 checks;

  i2cr_regs DUT (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .eng_i(eng_in), .eng_o(eng_out), .irq_o(irq)
  );

  i2cr_eng_model MODEL (
    .sys_clk_i(sys_clk_i),
    .eng_o    (eng_in)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task hang;
    err_count++;
    $display("mismatch at %0t: wait ran out", $time);
    results();
  endtask : hang

  // One single AHB-Lite transfer; entered and left just after a rising edge.
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin @(posedge sys_clk_i); n++; end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) hang();
  endtask : bus

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h00000000, x);
    chk(x, exp);
  endtask : rd

  task wait_irq(input logic exp);
    int n;
    n = 0;
    // Two edges pass first, so an interrupt that rises late is not missed when none is expected.
    repeat (2) @(posedge sys_clk_i);
    while (irq !== exp && n < 6)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    chk({31'h0, irq}, {31'h0, exp});
  endtask : wait_irq

  // Measures the second full gap so a divider change in mid-count does not skew it.
  task gap(input int u, input int exp);
    int c;
    for (int k = 0; k < 3; k++)
    begin
      c = 0;
      do begin @(posedge sys_clk_i); c++; end while (eng_out[u].bit_tick !== 1'b1 && c < 1200);
      if (c >= 1200) hang();
    end
    chk(c, exp);
  endtask : gap

  function automatic logic [31:0] ua(input int u, input logic [4:0] off);
    return 32'(u * 32) + 32'(off);
  endfunction : ua

  initial
  begin
    repeat (100000) @(posedge sys_clk_i);
    hang();
  end

  initial
  begin
    logic [31:0] iea;
    logic [31:0] ifa;
    err_count = 0;
    checks    = 0;
    rst_n_i   = 1'b0;
    hsel      = 1'b1;
    haddr     = 32'h00000000;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h00000000;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(32'h00000080, 32'h00000000);
    for (int u = 0; u < 2; u++)
    begin
      iea = 32'(i2cr_pkg::OFF_IE_U0) + 32'(u * 8);
      ifa = 32'(i2cr_pkg::OFF_IFG_U0) + 32'(u * 8);
      rd(ifa, 32'h00000008);
      rd(iea, 32'h00000000);
      rd(ua(u, i2cr_pkg::OFF_STATUS), 32'h00000000);
      wait_irq(1'b0);
      wr(iea, 32'h00000008);
      wait_irq(1'b1);
      wr(ua(u, i2cr_pkg::OFF_TXBUF), 32'h000000A5 + 32'(u));
      @(posedge sys_clk_i);
      chk({31'h0, eng_out[u].tx_full}, 32'h00000001);
      chk({24'h0, eng_out[u].tx_data}, 32'h000000A5 + 32'(u));
      rd(ifa, 32'h00000000);
      wait_irq(1'b0);
      MODEL.take(u);
      rd(ifa, 32'h00000008);
      rd(ua(u, i2cr_pkg::OFF_TXBUF), 32'h000000A5 + 32'(u));
      chk({24'h0, eng_out[u].tx_data}, 32'h000000A5 + 32'(u));
      wr(iea, 32'h00000004);
      wait_irq(1'b0);
      MODEL.rx(u, 8'h3C + 8'(u));
      rd(ifa, 32'h0000000C);
      wait_irq(1'b1);
      rd(ua(u, i2cr_pkg::OFF_RXBUF), 32'h0000003C + 32'(u));
      rd(ifa, 32'h00000008);
      wait_irq(1'b0);
      wr(iea, 32'h00000000);
      MODEL.lvl(u, 1'b1, 1'b1, 1'b0, 1'b0);
      repeat (2) @(posedge sys_clk_i);
      rd(ua(u, i2cr_pkg::OFF_STATUS), 32'h00000050);
      MODEL.lvl(u, 1'b0, 1'b0, 1'b0, 1'b0);
      MODEL.evt(u, i2cr_pkg::i2cr_evt_t'(5'h02));
      rd(ua(u, i2cr_pkg::OFF_STATUS), 32'h00000002);
      MODEL.evt(u, i2cr_pkg::i2cr_evt_t'(5'h04));
      rd(ua(u, i2cr_pkg::OFF_STATUS), 32'h00000004);
      MODEL.evt(u, i2cr_pkg::i2cr_evt_t'(5'h19));
      rd(ua(u, i2cr_pkg::OFF_STATUS), 32'h0000002D);
      wr(ua(u, i2cr_pkg::OFF_STATUS), 32'h000000FF);
      rd(ua(u, i2cr_pkg::OFF_STATUS), 32'h00000000);
      wr(ua(u, i2cr_pkg::OFF_EVT_IE), 32'h00000008);
      rd(ua(u, i2cr_pkg::OFF_EVT_IE), 32'h00000008);
      MODEL.evt(u, i2cr_pkg::i2cr_evt_t'(5'h01));
      wait_irq(1'b0);
      MODEL.evt(u, i2cr_pkg::i2cr_evt_t'(5'h08));
      wait_irq(1'b1);
      wr(ua(u, i2cr_pkg::OFF_STATUS), 32'h000000FF);
      wait_irq(1'b0);
      wr(ua(u, i2cr_pkg::OFF_EVT_IE), 32'h00000000);
      wr(ua(u, i2cr_pkg::OFF_PRE_LO), 32'h00000003);
      wr(ua(u, i2cr_pkg::OFF_PRE_HI), 32'h00000000);
      rd(ua(u, i2cr_pkg::OFF_PRE_LO), 32'h00000003);
      gap(u, 6);
      wr(ua(u, i2cr_pkg::OFF_PRE_LO), 32'h00000002);
      wr(ua(u, i2cr_pkg::OFF_PRE_HI), 32'h00000001);
      rd(ua(u, i2cr_pkg::OFF_PRE_HI), 32'h00000001);
      gap(u, 516);
      wr(ua(u, i2cr_pkg::OFF_TARGET), 32'h000003FF);
      rd(ua(u, i2cr_pkg::OFF_TARGET), 32'h000003FF);
      repeat (2) @(posedge sys_clk_i);
      chk({22'h0, eng_out[u].target}, 32'h00000000);
      MODEL.lvl(u, 1'b0, 1'b0, 1'b1, 1'b0);
      repeat (2) @(posedge sys_clk_i);
      chk({22'h0, eng_out[u].target}, 32'h0000007F);
      MODEL.lvl(u, 1'b0, 1'b0, 1'b1, 1'b1);
      repeat (2) @(posedge sys_clk_i);
      chk({22'h0, eng_out[u].target}, 32'h000003FF);
      MODEL.lvl(u, 1'b0, 1'b0, 1'b0, 1'b0);
      MODEL.rx(u, 8'h5A);
      rd(ifa, 32'h0000000C);
      wr(ifa, 32'h0000000C);
      rd(ifa, 32'h00000000);
      rd(ua(u, i2cr_pkg::OFF_RXBUF), 32'h0000005A);
    end
    chk({31'h0, hresp}, 32'h00000000);
    results();
  end
endmodule : i2c_serial_unit_registers_tb_top
`default_nettype wire
